// ### bench/cache_sync_and_trap_exec_tb.sv
// Self-checking bench for the cache-sync and trap execution unit.
// Assumes csx_exec as declared and the behavioural cache model at its far side.
`timescale 1ns/1ps
module cache_sync_and_trap_exec_tb;
  logic i_clk, i_resetn, i_ce, i_release1, i_icache_coherent, i_strongly_ordered;
  logic i_req_valid, i_xlate_kernel_fault, i_xlate_coherent, i_stores_pending, i_loads_pending;
  logic i_line_done, i_line_cache_err, i_line_bus_err, m_cerr, m_berr;
  logic o_req_ready, o_hold_stores, o_hold_loads, o_line_valid, o_line_skip_locked;
  logic o_watch_hit, o_exc, o_kill_writeback, o_done;
  logic [1:0] i_xlate_result;
  logic [3:0] m_delay;
  logic [31:0] o_xlate_addr;
  logic [csx_pkg::CACHE_LEVELS-1:0] o_line_levels;
  csx_pkg::csx_req_s i_req;
  csx_pkg::csx_line_s o_line;
  csx_pkg::csx_exc_s o_exc_info;
  int errors = 0;
  int samples_checked = 0;

  csx_exec DUT (.i_clk, .i_resetn, .i_ce, .i_release1, .i_icache_coherent, .i_strongly_ordered,
    .i_req_valid, .i_req, .o_req_ready, .o_xlate_addr, .i_xlate_result, .i_xlate_kernel_fault,
    .i_xlate_coherent, .i_stores_pending, .i_loads_pending, .o_hold_stores, .o_hold_loads,
    .o_line_valid, .o_line, .o_line_levels, .o_line_skip_locked, .i_line_done,
    .i_line_cache_err, .i_line_bus_err, .o_watch_hit, .o_exc, .o_exc_info, .o_kill_writeback,
    .o_done);
  csx_cache_model far_side (.i_clk, .i_resetn, .i_line_valid(o_line_valid), .i_delay(m_delay),
    .i_cache_err(m_cerr), .i_bus_err(m_berr), .o_done(i_line_done),
    .o_cache_err(i_line_cache_err), .o_bus_err(i_line_bus_err));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: bit %b exp %b", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: word %h exp %h", $time, got, exp);
    end
  endtask

  // Entered at a falling edge; returns at the falling edge after the take
  task automatic issue(input csx_pkg::csx_op_e op, input logic [31:0] l, input logic [31:0] r,
      input logic [15:0] off);
    int n = 0;
    i_req.op = op;
    i_req.left_operand_reg = l;
    i_req.right_operand_reg = r;
    i_req.offset = off;
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    if (o_req_ready !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: request never taken", $time);
      conclude();
    end
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask

  task automatic answer(input logic exp_exc, input logic [4:0] cause, input int lim);
    int n = 0;
    while (o_done !== 1'b1 && o_exc !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    if (o_done !== 1'b1 && o_exc !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: no answer in time", $time);
      conclude();
    end
    check_bit(o_exc, exp_exc);
    check_bit(o_kill_writeback, exp_exc);
    if (exp_exc) check_word(32'(o_exc_info.cause), 32'(cause));
    @(negedge i_clk);
    check_bit(o_done | o_exc, 1'b0);
  endtask

  task automatic t_system_call_instruction();
    for (int k = 0; k < 2; k++) begin
      i_req.code = k ? 20'hFFFFF : 20'h00000;
      issue(csx_pkg::CSX_OP_SYSTEM_CALL_INSTRUCTION, 32'h5, 32'h5, 16'hFFFF);
      answer(1'b1, csx_pkg::CAUSE_SYSTEM_CALL_INSTRUCTION, 0);
    end
    $display("test system_call_instruction done");
  endtask

  task automatic t_trap();
    logic [31:0] l [4] = '{32'h5, 32'hFFFFFFFF, 32'h80000000, 32'h1};
    logic [31:0] r [4] = '{32'h5, 32'hFFFFFFFF, 32'h00000000, 32'h2};
    for (int k = 0; k < 4; k++) begin
      i_req.code = 20'(k);
      issue(csx_pkg::CSX_OP_TRAP_EQ, l[k], r[k], 16'h0000);
      answer(l[k] == r[k], csx_pkg::CAUSE_TRAP, 0);
    end
    $display("test trap done");
  endtask

  task automatic t_line(input logic [31:0] base, input logic [15:0] off, input logic [31:0] ea,
      input logic coh, input logic [3:0] dly);
    i_xlate_coherent = coh;
    m_delay = dly;
    issue(csx_pkg::CSX_OP_LINE_SYNC, base, 32'h0, off);
    check_word(o_xlate_addr, ea);
    check_word(o_line.addr, ea);
    check_bit(o_line_valid, 1'b1);
    check_bit(o_line.broadcast, coh);
    check_word(32'(o_line_levels), (32'h1 << csx_pkg::CACHE_LEVELS) - 32'h1);
    check_bit(o_line_skip_locked, 1'b1);
    check_bit(o_watch_hit, 1'b0);
    answer(1'b0, 5'h00, 12);
    $display("test line sync done");
  endtask

  task automatic t_line_err();
    logic [4:0] c [3] = '{csx_pkg::CAUSE_CACHE_ERR, csx_pkg::CAUSE_BUS_ERR,
      csx_pkg::CAUSE_CACHE_ERR};
    for (int k = 0; k < 3; k++) begin
      m_cerr = (k != 1);
      m_berr = (k != 0);
      m_delay = 4'(k);
      issue(csx_pkg::CSX_OP_LINE_SYNC, 32'h40, 32'h0, 16'h0000);
      answer(1'b1, c[k], 12);
      check_word(o_exc_info.bad_addr, 32'h00000040);
    end
    m_cerr = 1'b0;
    m_berr = 1'b0;
    $display("test line error done");
  endtask

  task automatic t_line_fault();
    logic [1:0] res [3] = '{csx_pkg::XLATE_REFILL, csx_pkg::XLATE_INVALID, csx_pkg::XLATE_OK};
    logic [4:0] c [3] = '{csx_pkg::CAUSE_TLB_REFILL_LOAD, csx_pkg::CAUSE_TLB_INVALID_LOAD,
      csx_pkg::CAUSE_ADDR_ERR_LOAD};
    for (int k = 0; k < 3; k++) begin
      i_xlate_result = res[k];
      i_xlate_kernel_fault = (k == 2);
      issue(csx_pkg::CSX_OP_LINE_SYNC, 32'h80001000, 32'h0, 16'h0000);
      check_bit(o_line_valid, 1'b0);
      answer(1'b1, c[k], 0);
      check_word(o_exc_info.bad_addr, 32'h80001000);
    end
    i_xlate_result = csx_pkg::XLATE_OK;
    i_xlate_kernel_fault = 1'b0;
    i_release1 = 1'b1;
    issue(csx_pkg::CSX_OP_LINE_SYNC, 32'h100, 32'h0, 16'h0000);
    answer(1'b1, csx_pkg::CAUSE_RESV_INSTR, 0);
    i_release1 = 1'b0;
    i_icache_coherent = 1'b1;
    issue(csx_pkg::CSX_OP_LINE_SYNC, 32'h100, 32'h0, 16'h0000);
    check_bit(o_line_valid, 1'b0);
    answer(1'b0, 5'h00, 0);
    i_icache_coherent = 1'b0;
    $display("test line fault done");
  endtask

  task automatic t_barrier();
    i_stores_pending = 1'b1;
    i_loads_pending = 1'b1;
    issue(csx_pkg::CSX_OP_BARRIER, 32'h0, 32'h0, 16'h0000);
    check_bit(o_hold_stores, 1'b1);
    check_bit(o_hold_loads, 1'b1);
    // Clock enable low must freeze the barrier even though stores have drained
    i_ce = 1'b0;
    i_stores_pending = 1'b0;
    repeat (3) @(negedge i_clk);
    check_bit(o_hold_stores, 1'b1);
    check_bit(o_done | o_req_ready, 1'b0);
    i_ce = 1'b1;
    repeat (2) @(negedge i_clk);
    check_bit(o_hold_stores, 1'b0);
    check_bit(o_hold_loads, 1'b1);
    check_bit(o_done | o_req_ready, 1'b0);
    i_loads_pending = 1'b0;
    answer(1'b0, 5'h00, 3);
    i_strongly_ordered = 1'b1;
    i_stores_pending = 1'b1;
    issue(csx_pkg::CSX_OP_BARRIER, 32'h0, 32'h0, 16'h0000);
    answer(1'b0, 5'h00, 0);
    i_strongly_ordered = 1'b0;
    i_stores_pending = 1'b0;
    $display("test barrier done");
  endtask

  initial begin
    {i_resetn, i_release1, i_icache_coherent, i_strongly_ordered, i_req_valid} = '0;
    {i_xlate_kernel_fault, i_xlate_coherent, i_stores_pending, i_loads_pending} = '0;
    {m_cerr, m_berr, m_delay, i_xlate_result} = '0;
    i_req = '0;
    i_ce = 1'b1;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    t_system_call_instruction();
    t_trap();
    t_line(32'h00001000, 16'hFFF0, 32'h00000FF0, 1'b1, 4'h0);
    t_line(32'h00000000, 16'h7FF0, 32'h00007FF0, 1'b0, 4'h5);
    t_line_err();
    t_line_fault();
    // Line sync tests are done and are followed by the barrier test
    t_barrier();
    conclude();
  end
endmodule

// ### bench/csx_cache_model.sv
// Behavioural cache hierarchy that answers line synchronise requests.
// Assumes the requester holds its line request until it sees the done pulse.
`timescale 1ns/1ps
module csx_cache_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Request and scenario controls
  input wire logic i_line_valid,
  input wire logic [3:0] i_delay,
  input wire logic i_cache_err,
  input wire logic i_bus_err,
  // Answer
  output logic o_done,
  output logic o_cache_err,
  output logic o_bus_err
);
  logic [3:0] cnt;
  logic tog;
  // Error flags only mean something with done; toggle them otherwise so stale values never match
  assign o_cache_err = o_done ? i_cache_err : tog;
  assign o_bus_err = o_done ? i_bus_err : ~tog;
  // Done pulse comes i_delay+1 clock edges after the request is seen; no line, level or lock state is modelled
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt <= 4'h0;
      o_done <= 1'b0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      if (i_line_valid && !o_done) begin
        cnt <= (cnt == i_delay) ? 4'h0 : cnt + 4'h1;
        o_done <= (cnt == i_delay);
      end else begin
        o_done <= 1'b0;
      end
    end
  end
endmodule

// ### core/csx_addr_gen.sv
// Effective address adder for the line synchronise operation.
// Assumes base and offset are stable while the request is presented.
`timescale 1ns/1ps
module csx_addr_gen (
  // Operands
  input wire logic [csx_pkg::ADDR_W-1:0] i_base,
  input wire logic [csx_pkg::OFFS_W-1:0] i_offset,
  // Result
  output logic [csx_pkg::ADDR_W-1:0] o_addr
);
  logic [csx_pkg::ADDR_W-1:0] offset_sx;

  // Sign extension by replication of the top offset bit
  assign offset_sx = {{(csx_pkg::ADDR_W - csx_pkg::OFFS_W){i_offset[csx_pkg::OFFS_W-1]}},
    i_offset};
  assign o_addr = i_base + offset_sx;
endmodule

// ### core/csx_exec.sv
// Execution unit for barrier, line synchronise, system call and trap-on-equal.
// Assumes a decoder that holds i_req_valid until o_req_ready, a translator
// that answers the same cycle, and a cache hierarchy that acknowledges.
// Notes on behaviour
// - Stores before a barrier become globally performed before later stores.
// - Loads after a barrier wait until earlier loads are determined.
// - Line address is base plus sign-extended 16-bit offset.
// - Only the one line holding the address is synchronised, all needed levels.
// - Line synchronise runs in every mode, user mode included.
// - Only load-cause translation faults; never modified or store-cause faults.
// - Writeback cache or bus error raises cache error; bus fault raises bus error.
// - Kernel address that would fault may raise load address error.
// - Broadcast only when the address is coherent cacheable.
// - All affected cache levels share the same broadcast choice.
// - With hardware-coherent instruction caches the line sync is a no-op.
// - Locked lines are left untouched by line synchronise.
// - Acts on local caches at least; shared levels as needed.
// - First-release cores raise reserved instruction for line synchronise.
// - Data watch on line synchronise is fixed by the implementation.
// - System call raises its exception at once, unconditionally.
// - Code field of system call and trap is ignored by hardware.
// - Trap on equal compares operands signed, traps when equal.
// - Barrier on a strongly ordered system acts as no-op, no error.
`timescale 1ns/1ps
module csx_exec (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Configuration straps
  input wire logic i_release1,
  input wire logic i_icache_coherent,
  input wire logic i_strongly_ordered,
  // Request from the decoder
  input wire logic i_req_valid,
  input wire csx_pkg::csx_req_s i_req,
  output logic o_req_ready,
  // Translation of the effective address
  output logic [csx_pkg::ADDR_W-1:0] o_xlate_addr,
  input wire logic [1:0] i_xlate_result,
  input wire logic i_xlate_kernel_fault,
  input wire logic i_xlate_coherent,
  // Memory ordering status
  input wire logic i_stores_pending,
  input wire logic i_loads_pending,
  output logic o_hold_stores,
  output logic o_hold_loads,
  // Line synchronise to the cache hierarchy
  output logic o_line_valid,
  output csx_pkg::csx_line_s o_line,
  output logic [csx_pkg::CACHE_LEVELS-1:0] o_line_levels,
  output logic o_line_skip_locked,
  input wire logic i_line_done,
  input wire logic i_line_cache_err,
  input wire logic i_line_bus_err,
  // Watch and exceptions
  output logic o_watch_hit,
  output logic o_exc,
  output csx_pkg::csx_exc_s o_exc_info,
  output logic o_kill_writeback,
  output logic o_done
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BARRIER = 2'b01,
    ST_LINE = 2'b10
  } csx_state_e;

  csx_state_e state;
  csx_state_e next_state;
  logic [csx_pkg::ADDR_W-1:0] eff_addr;
  logic take;
  logic raise;
  csx_pkg::csx_exc_s next_exc;
  logic next_done;
  logic line_fault;

  csx_addr_gen u_addr (
    .i_base(i_req.left_operand_reg),
    .i_offset(i_req.offset),
    .o_addr(eff_addr)
  );

  assign o_xlate_addr = eff_addr;
  // Single-cycle ops are taken from idle; multi-cycle ones hold the decoder
  assign o_req_ready = (state == ST_IDLE) && i_ce;
  assign take = i_req_valid && o_req_ready;

  // Translation faults of line sync are load-type only
  always_comb begin
    line_fault = 1'b0;
    next_exc = '0;
    next_exc.bad_addr = eff_addr;
    if (i_xlate_kernel_fault && csx_pkg::KERNEL_ADDR_ERR_EN) begin
      line_fault = 1'b1;
      next_exc.cause = csx_pkg::CAUSE_ADDR_ERR_LOAD;
    end else if (i_xlate_result == csx_pkg::XLATE_REFILL) begin
      line_fault = 1'b1;
      next_exc.cause = csx_pkg::CAUSE_TLB_REFILL_LOAD;
    end else if (i_xlate_result == csx_pkg::XLATE_INVALID) begin
      line_fault = 1'b1;
      next_exc.cause = csx_pkg::CAUSE_TLB_INVALID_LOAD;
    end
  end

  // Decide the action for the request taken this cycle
  always_comb begin
    next_state = state;
    raise = 1'b0;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (take) begin
          case (i_req.op)
            csx_pkg::CSX_OP_BARRIER: begin
              // Already ordered: retire at once
              if (i_strongly_ordered || (!i_stores_pending && !i_loads_pending)) begin
                next_done = 1'b1;
              end else begin
                next_state = ST_BARRIER;
              end
            end
            csx_pkg::CSX_OP_LINE_SYNC: begin
              // No privilege check anywhere in this path
              if (i_release1) begin
                raise = 1'b1;
              end else if (line_fault) begin
                raise = 1'b1;
              end else if (i_icache_coherent) begin
                next_done = 1'b1;
              end else begin
                next_state = ST_LINE;
              end
            end
            csx_pkg::CSX_OP_SYSTEM_CALL_INSTRUCTION: begin
              raise = 1'b1;
            end
            csx_pkg::CSX_OP_TRAP_EQ: begin
              // Signed equality equals bitwise equality; code field unused
              if ($signed(i_req.left_operand_reg) == $signed(i_req.right_operand_reg)) begin
                raise = 1'b1;
              end else begin
                next_done = 1'b1;
              end
            end
            default: begin
              next_done = 1'b0;
            end
          endcase
        end
      end
      ST_BARRIER: begin
        if (!i_stores_pending && !i_loads_pending) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      end
      ST_LINE: begin
        if (i_line_done) begin
          next_state = ST_IDLE;
          if (i_line_cache_err || i_line_bus_err) begin
            raise = 1'b1;
          end else begin
            next_done = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Barrier holds later accesses until earlier ones are performed
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_hold_stores <= 1'b0;
      o_hold_loads <= 1'b0;
    end else if (i_ce) begin
      o_hold_stores <= (next_state == ST_BARRIER) && i_stores_pending;
      o_hold_loads <= (next_state == ST_BARRIER) && i_loads_pending;
    end
  end

  // Line request; one line, one broadcast choice for all levels
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_line_valid <= 1'b0;
      o_line <= '0;
      o_line_levels <= '0;
      o_line_skip_locked <= 1'b0;
    end else if (i_ce) begin
      if (state == ST_IDLE && next_state == ST_LINE) begin
        o_line_valid <= 1'b1;
        o_line.addr <= eff_addr;
        o_line.broadcast <= i_xlate_coherent;
        o_line_levels <= '1;
        o_line_skip_locked <= 1'b1;
      end else if (state == ST_LINE && i_line_done) begin
        o_line_valid <= 1'b0;
      end
    end
  end

  // Exception and retire outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_exc <= 1'b0;
      o_exc_info <= '0;
      o_kill_writeback <= 1'b0;
      o_done <= 1'b0;
      o_watch_hit <= 1'b0;
    end else if (i_ce) begin
      o_exc <= raise;
      o_kill_writeback <= raise;
      o_done <= next_done;
      o_watch_hit <= 1'b0;
      if (raise) begin
        if (state == ST_LINE) begin
          o_exc_info.cause <= i_line_cache_err ? csx_pkg::CAUSE_CACHE_ERR :
            csx_pkg::CAUSE_BUS_ERR;
          o_exc_info.bad_addr <= o_line.addr;
        end else if (i_req.op == csx_pkg::CSX_OP_SYSTEM_CALL_INSTRUCTION) begin
          o_exc_info <= '0;
          o_exc_info.cause <= csx_pkg::CAUSE_SYSTEM_CALL_INSTRUCTION;
        end else if (i_req.op == csx_pkg::CSX_OP_TRAP_EQ) begin
          o_exc_info <= '0;
          o_exc_info.cause <= csx_pkg::CAUSE_TRAP;
        end else if (i_release1) begin
          o_exc_info <= '0;
          o_exc_info.cause <= csx_pkg::CAUSE_RESV_INSTR;
        end else begin
          o_exc_info <= next_exc;
        end
      end
      if (take && i_req.op == csx_pkg::CSX_OP_LINE_SYNC) begin
        o_watch_hit <= csx_pkg::WATCH_ON_LINE_SYNC;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !i_ce);

  a_system_call_instruction_raise: assert property (
    take && i_req.op == csx_pkg::CSX_OP_SYSTEM_CALL_INSTRUCTION |=> o_exc &&
      o_exc_info.cause == csx_pkg::CAUSE_SYSTEM_CALL_INSTRUCTION)
    else $error("system_call_instruction did not raise");
  a_trap_equal: assert property (
    take && i_req.op == csx_pkg::CSX_OP_TRAP_EQ &&
      i_req.left_operand_reg == i_req.right_operand_reg |=> o_exc &&
      o_exc_info.cause == csx_pkg::CAUSE_TRAP)
    else $error("trap on equal missed");
  a_trap_noteq: assert property (
    take && i_req.op == csx_pkg::CSX_OP_TRAP_EQ &&
      i_req.left_operand_reg != i_req.right_operand_reg |=> !o_exc && o_done)
    else $error("spurious trap");
  a_precise_kill: assert property (o_exc |-> o_kill_writeback)
    else $error("exception without write kill");
  a_release1_resv: assert property (
    take && i_req.op == csx_pkg::CSX_OP_LINE_SYNC && i_release1 |=>
      o_exc_info.cause == csx_pkg::CAUSE_RESV_INSTR && !o_line_valid)
    else $error("release 1 line sync not reserved");
  a_line_addr: assert property (
    o_line_valid && !$past(o_line_valid) |-> o_line.addr == $past(eff_addr))
    else $error("line address wrong");
  a_line_coh_nop: assert property (
    take && i_req.op == csx_pkg::CSX_OP_LINE_SYNC && !i_release1 && !line_fault &&
      i_icache_coherent |=> !o_line_valid && o_done)
    else $error("coherent line sync not a no-op");
  a_no_store_cause: assert property (
    take && i_req.op == csx_pkg::CSX_OP_LINE_SYNC && !i_release1 && line_fault |=>
      o_exc && (o_exc_info.cause == csx_pkg::CAUSE_TLB_REFILL_LOAD ||
      o_exc_info.cause == csx_pkg::CAUSE_TLB_INVALID_LOAD ||
      o_exc_info.cause == csx_pkg::CAUSE_ADDR_ERR_LOAD))
    else $error("line fault not reported with a load cause");
  a_line_error: assert property (
    state == ST_LINE && i_line_done && i_line_bus_err && !i_line_cache_err |=>
      o_exc && o_exc_info.cause == csx_pkg::CAUSE_BUS_ERR)
    else $error("bus error not reported");
  a_barrier_hold: assert property (
    state == ST_BARRIER && i_stores_pending |-> ##[0:1] o_hold_stores)
    else $error("stores not held behind barrier");
  a_strong_nop: assert property (
    take && i_req.op == csx_pkg::CSX_OP_BARRIER && i_strongly_ordered |=>
      o_done && !o_exc ##1 state == ST_IDLE)
    else $error("ordered barrier not a no-op");

  // Request handshake and outcome
  a_ready_busy: assert property (state != ST_IDLE |-> !o_req_ready)
    else $error("request accepted while busy");
  a_one_outcome: assert property (!(o_done && o_exc))
    else $error("retire and exception together");
  a_kill_only_exc: assert property (o_kill_writeback |-> o_exc)
    else $error("write kill without exception");
  a_exc_info_hold: assert property (!o_exc |-> $stable(o_exc_info))
    else $error("exception info changed without exception");

  // Barrier ordering
  a_hold_loads: assert property (
    state == ST_BARRIER && i_loads_pending |=> o_hold_loads)
    else $error("loads not held behind barrier");
  a_hold_release: assert property (
    o_hold_stores || o_hold_loads |-> state == ST_BARRIER)
    else $error("access hold outside a barrier");
  a_strong_no_hold: assert property (
    take && i_req.op == csx_pkg::CSX_OP_BARRIER && i_strongly_ordered |=>
      !o_hold_stores && !o_hold_loads)
    else $error("ordered barrier held accesses");
  a_barrier_retire: assert property (
    state == ST_BARRIER && !i_stores_pending && !i_loads_pending |=>
      o_done && state == ST_IDLE && !o_hold_stores && !o_hold_loads)
    else $error("barrier did not retire");

  // Line request towards the caches
  a_line_bcast: assert property (
    o_line_valid && !$past(o_line_valid) |-> o_line.broadcast == $past(i_xlate_coherent))
    else $error("broadcast choice wrong");
  a_line_levels: assert property (
    o_line_valid |-> o_line_levels == '1 && o_line_skip_locked)
    else $error("line request not uniform");
  a_line_hold: assert property (
    o_line_valid && !i_line_done |=> o_line_valid && $stable(o_line.addr))
    else $error("line request dropped early");
  a_line_retire: assert property (
    state == ST_LINE && i_line_done && !i_line_cache_err && !i_line_bus_err |=>
      o_done && !o_exc && !o_line_valid)
    else $error("line sync did not retire");
  a_cache_err_first: assert property (
    state == ST_LINE && i_line_done && i_line_cache_err |=>
      o_exc && o_exc_info.cause == csx_pkg::CAUSE_CACHE_ERR)
    else $error("cache error not reported");
  a_watch_fixed: assert property (
    take && i_req.op == csx_pkg::CSX_OP_LINE_SYNC |=>
      o_watch_hit == csx_pkg::WATCH_ON_LINE_SYNC)
    else $error("watch on line sync not fixed");

  c_line_done: cover property (state == ST_LINE && i_line_done && !i_line_cache_err);
  c_barrier_wait: cover property (state == ST_BARRIER [*3] ##1 state == ST_IDLE);
  c_trap_taken: cover property (o_exc && o_exc_info.cause == csx_pkg::CAUSE_TRAP);
  c_broadcast: cover property (o_line_valid && o_line.broadcast);
  c_line_fault: cover property (o_exc && o_exc_info.cause == csx_pkg::CAUSE_ADDR_ERR_LOAD);

endmodule

// ### core/csx_pkg.sv
// Package for the cache-sync and trap execution unit.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package csx_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned OFFS_W = 16;
  localparam int unsigned CODE_W = 20;
  localparam int unsigned CAUSE_W = 5;

  // Opcode classes presented by the decoder
  typedef enum logic [2:0] {
    CSX_OP_NONE = 3'h0,
    CSX_OP_BARRIER = 3'h1,
    CSX_OP_LINE_SYNC = 3'h2,
    CSX_OP_SYSTEM_CALL_INSTRUCTION = 3'h3,
    CSX_OP_TRAP_EQ = 3'h4
  } csx_op_e;

  // Exception cause codes reported with o_exc
  localparam logic [CAUSE_W-1:0] CAUSE_ADDR_ERR_LOAD = 5'h04;
  localparam logic [CAUSE_W-1:0] CAUSE_BUS_ERR = 5'h07;
  localparam logic [CAUSE_W-1:0] CAUSE_SYSTEM_CALL_INSTRUCTION = 5'h08;
  localparam logic [CAUSE_W-1:0] CAUSE_RESV_INSTR = 5'h0A;
  localparam logic [CAUSE_W-1:0] CAUSE_TRAP = 5'h0D;
  localparam logic [CAUSE_W-1:0] CAUSE_CACHE_ERR = 5'h1E;
  localparam logic [CAUSE_W-1:0] CAUSE_TLB_REFILL_LOAD = 5'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_TLB_INVALID_LOAD = 5'h03;

  // Translation result from the address translator
  localparam logic [1:0] XLATE_OK = 2'h0;
  localparam logic [1:0] XLATE_REFILL = 2'h1;
  localparam logic [1:0] XLATE_INVALID = 2'h2;

  // Implementation choices
  localparam logic KERNEL_ADDR_ERR_EN = 1'b1;
  localparam logic WATCH_ON_LINE_SYNC = 1'b0;
  localparam logic [3:0] CACHE_LEVELS = 4'h2;

  typedef struct packed {
    csx_op_e op;
    logic [ADDR_W-1:0] left_operand_reg;
    logic [ADDR_W-1:0] right_operand_reg;
    logic [OFFS_W-1:0] offset;
    logic [CODE_W-1:0] code;
  } csx_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic broadcast;
  } csx_line_s;

  typedef struct packed {
    logic [CAUSE_W-1:0] cause;
    logic [ADDR_W-1:0] bad_addr;
  } csx_exc_s;

endpackage
